// >>> logic/ax25_pkg.sv
/*
  ax25_pkg: constants shared by the packet frame codec and its FIFO.
  assumes nothing beyond a SystemVerilog compiler.
*/
package ax25_pkg;
  localparam int          CLK_HZ        = 100_000_000;
  localparam int          BIT_RATE_HZ   = 1200;
  localparam int          BIT_DIV       = CLK_HZ / BIT_RATE_HZ;
  localparam int          TX_FIFO_DEPTH = 8;
  localparam int          TX_FIFO_WIDTH = 9;
  localparam logic [7:0]  FLAG_BYTE     = 8'h7E;
  localparam logic [2:0]  STUFF_RUN     = 3'h5;
  localparam logic [4:0]  ABORT_ONES    = 5'hF;
  localparam logic [3:0]  FCS_LAST_BIT  = 4'hF;
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REV  = 16'h8408;
  localparam logic [11:0] MIN_FRAME_BITS = 12'h088;
  localparam logic [8:0]  MAX_INFO      = 9'h100;
  localparam logic [3:0]  RAW_SKIP      = 4'h7;
  localparam logic [4:0]  SUB_LEN       = 5'h7;
  localparam logic [2:0]  SSID_POS      = 3'h6;
  localparam logic [4:0]  LAST_ADDR_DIR = 5'hD;
  localparam logic [4:0]  LAST_ADDR_RPT = 5'h14;
  localparam logic [8:0]  DST_SSID_IDX  = 9'h006;
  localparam logic [8:0]  SRC_SSID_IDX  = 9'h00D;
  localparam logic [8:0]  RPT_SSID_IDX  = 9'h014;
  localparam logic [7:0]  ASCII_SPACE   = 8'h20;
  localparam logic [1:0]  RSV_BITS      = 2'h3;
  localparam logic [3:0]  SSID_ALLCALL  = 4'hF;
  localparam logic [7:0]  CTRL_PF_MASK  = 8'hEF;
  localparam logic [7:0]  CTRL_UI       = 8'h03;
  localparam logic [7:0]  CTRL_FRMR     = 8'h87;
  localparam logic [7:0]  PID_NONE_VAL  = 8'hF0;
  localparam logic [7:0]  PID_ESC_VAL   = 8'hFF;
  typedef enum logic [1:0] {PID_RSVD, PID_L3, PID_NONE, PID_ESC} ax25_pid_t;
endpackage : ax25_pkg

// >>> logic/ax25_frame_codec.sv
/*
  ax25_frame_codec: bit-level framer and deframer for packet-radio frames,
  plus ax25_tx_fifo, the byte buffer in front of the framer.
  assumes the modem takes txBit on txBitStrobe and offers rxBit with a
  one-cycle rxBitValid, both synchronous to clk_sys; call ports stable
  while txBusy is high.
*/
// Overview of operation
// - frames open and close with flag 7E
// - flag pattern only delimits frames
// - insert zero after five ones sent
// - drop zero after five ones received
// - fields go out least significant bit first
// - check sequence goes out msb first
// - both ends compute sixteen-bit check sequence
// - abort sends fifteen ones (sixteen when started by txAbort), no stuffing
// - reject short, unflagged or unaligned frames
// - whole-octet fields, one-octet control field
// - protocol identifier only in information frames
// - info only in I/UI/FRMR, max 256
// - info carried unchanged end to end
// - address bit 0 marks final octet
// - upper-case callsigns shifted, space padded
// - destination seven octets, then source seven
// - address octets from A1, bit 0 first
// - reserved identifier bits sent as one
// - all-ones station id is all-call
// - repeater sub-field follows cleared extension bit
// - last repeater octet holds repeated bit
// - repeated bit zero until repeater sends
`timescale 1ns/1ns
`default_nettype none

module ax25_tx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outValid = (cnt_q != '0);
  assign outData  = mem[rdPtr_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q   <= '0;
      inReady <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      cnt_q   <= cnt_d;
      inReady <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule : ax25_tx_fifo

module ax25_frame_codec import ax25_pkg::*; #(
  parameter int BIT_DIVIDE = BIT_DIV,
  parameter int FIFO_DEPTH = TX_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // transmit bytes: control, pid, info; last marks final byte
  input  wire logic        txValid,
  input  wire logic [7:0]  txData,
  input  wire logic        txLast,
  output logic             txReady,
  input  wire logic        txAbort,
  // transmit address
  input  wire logic [47:0] dstCall,
  input  wire logic [3:0]  dstSsid,
  input  wire logic [47:0] srcCall,
  input  wire logic [3:0]  srcSsid,
  input  wire logic        rptEnable,
  input  wire logic [47:0] rptCall,
  input  wire logic [3:0]  rptSsid,
  input  wire logic        rptDone,
  // modem transmit stream
  output logic             txBit_q,
  output logic             txBitStrobe_q,
  output logic             txBusy_q,
  // modem receive stream
  input  wire logic        rxBit,
  input  wire logic        rxBitValid,
  // receive bytes and frame verdict
  output logic [7:0]       rxData_q,
  output logic             rxValid_q,
  output logic             rxFrameOk_q,
  output logic             rxFrameBad_q,
  output logic             rxHasRpt_q,
  output logic             rxRepeated_q,
  output logic             rxAllCall_q,
  output ax25_pid_t        rxPidClass_q
);
  typedef enum logic [2:0] {TX_IDLE, TX_ADDR, TX_DATA, TX_FCS, TX_ABORT} ax25_txst_t;

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b);
    crcStep = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1);
  endfunction : crcStep

  function automatic logic [7:0] encChar(input logic [7:0] ch);
    logic [7:0] u;
    u = (ch == 8'h00) ? ASCII_SPACE : ch;
    if (u >= 8'h61 && u <= 8'h7A) begin
      u = u - ASCII_SPACE;
    end
    encChar = {u[6:0], 1'b0};
  endfunction : encChar

  // bit-rate enable
  logic [$clog2(BIT_DIVIDE+1)-1:0] div_q;
  logic bitEn;
  assign bitEn = (div_q == '0);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= bitEn ? ($bits(div_q))'(BIT_DIVIDE - 1) : div_q - 1'b1;
    end
  end

  // transmit buffer
  logic       fifoValid;
  logic [8:0] fifoData;
  logic       fifoPop;
  ax25_tx_fifo #(.WIDTH(TX_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inValid  (txValid),
    .inData   ({txLast, txData}),
    .inReady  (txReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .outReady (fifoPop)
  );

  // transmit framer state
  ax25_txst_t  txSt_q;
  logic [7:0]  txSh_q;
  logic [2:0]  txIdx_q;
  logic [4:0]  txByte_q;
  logic [2:0]  txOnes_q;
  logic [15:0] txCrc_q;
  logic [15:0] txFcs_q;
  logic [4:0]  txCnt_q;
  logic        txLastB_q;
  logic [8:0]  txInfo_q;

  logic        stuffing;
  logic        stuffNow;
  logic        curBit;
  logic        byteEnd;
  logic [15:0] crcNext;
  logic [4:0]  nIdx;
  logic [4:0]  lastAddr;
  logic [7:0]  addrOct;

  // idle included so five trailing check ones still get their zero
  assign stuffing = (txSt_q != TX_ABORT);
  assign stuffNow = stuffing && (txOnes_q == STUFF_RUN);
  assign curBit   = (txSt_q == TX_FCS) ? txFcs_q[15] : txSh_q[txIdx_q];
  assign byteEnd  = bitEn && !stuffNow && (txIdx_q == 3'h7);
  assign crcNext  = crcStep(txCrc_q, curBit);
  assign lastAddr = rptEnable ? LAST_ADDR_RPT : LAST_ADDR_DIR;
  assign nIdx     = (txSt_q == TX_IDLE) ? 5'h0 : txByte_q + 1'b1;
  assign fifoPop  = byteEnd && fifoValid && !txAbort &&
                    (((txSt_q == TX_ADDR) && (txByte_q == lastAddr)) ||
                     ((txSt_q == TX_DATA) && !txLastB_q));

  // address octet for index nIdx, sent from A1 onward
  always_comb begin
    logic [47:0] call;
    logic [3:0]  ssid;
    logic [2:0]  pos;
    logic [1:0]  sub;
    call = dstCall;
    ssid = dstSsid;
    sub  = 2'h0;
    pos  = 3'h0;
    if (nIdx >= (SUB_LEN << 1)) begin
      sub = 2'h2;
    end else if (nIdx >= SUB_LEN) begin
      sub = 2'h1;
    end
    pos = 3'(nIdx - 5'(sub) * SUB_LEN);
    if (sub == 2'h1) begin
      call = srcCall;
      ssid = srcSsid;
    end else if (sub == 2'h2) begin
      call = rptCall;
      ssid = rptSsid;
    end
    if (pos == SSID_POS) begin
      // top bit is the repeated flag on the repeater octet
      addrOct = {((sub == 2'h2) ? rptDone : 1'b1), RSV_BITS, ssid, (nIdx == lastAddr)};
    end else begin
      addrOct = encChar(call[8*(5-int'(pos)) +: 8]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txSt_q        <= TX_IDLE;
      txSh_q        <= '0;
      txIdx_q       <= '0;
      txByte_q      <= '0;
      txOnes_q      <= '0;
      txCrc_q       <= CRC_INIT;
      txFcs_q       <= '0;
      txCnt_q       <= '0;
      txLastB_q     <= 1'b0;
      txInfo_q      <= '0;
      txBit_q       <= 1'b1;
      txBitStrobe_q <= 1'b0;
      txBusy_q      <= 1'b0;
    end else begin
      txBitStrobe_q <= bitEn;
      txBusy_q      <= (txSt_q != TX_IDLE);
      if (bitEn) begin
        case (txSt_q)
          TX_IDLE: begin
            if (stuffNow) begin
              txBit_q  <= 1'b0;
              txOnes_q <= '0;
            end else begin
              txBit_q <= FLAG_BYTE[txIdx_q];
              txIdx_q <= txIdx_q + 1'b1;
              if (txIdx_q == 3'h7 && fifoValid) begin
                txSt_q    <= TX_ADDR;
                txSh_q    <= addrOct;
                txByte_q  <= '0;
                txOnes_q  <= '0;
                txCrc_q   <= CRC_INIT;
                txInfo_q  <= '0;
                txLastB_q <= 1'b0;
              end
            end
          end
          TX_ADDR, TX_DATA, TX_FCS: begin
            if (txAbort) begin
              txSt_q  <= TX_ABORT;
              txCnt_q <= '0;
              txBit_q <= 1'b1;
            end else if (stuffNow) begin
              txBit_q  <= 1'b0;
              txOnes_q <= '0;
            end else begin
              txBit_q  <= curBit;
              txOnes_q <= curBit ? txOnes_q + 1'b1 : 3'h0;
              if (txSt_q == TX_FCS) begin
                txFcs_q <= txFcs_q << 1;
                txCnt_q <= txCnt_q + 1'b1;
                if (txCnt_q == 5'(FCS_LAST_BIT)) begin
                  txSt_q  <= TX_IDLE; // closing flag follows
                  txIdx_q <= '0;
                end
              end else begin
                txCrc_q <= crcNext;
                txIdx_q <= txIdx_q + 1'b1;
                if (txIdx_q == 3'h7) begin
                  txByte_q <= nIdx;
                  if (txSt_q == TX_DATA && txLastB_q) begin
                    txSt_q  <= TX_FCS;
                    txFcs_q <= ~crcNext;
                    txCnt_q <= '0;
                  end else if (!fifoValid || txInfo_q > MAX_INFO + 9'h1) begin
                    txSt_q  <= TX_ABORT; // underrun or oversize info
                    txCnt_q <= '0;
                  end else if (txSt_q == TX_DATA || txByte_q == lastAddr) begin
                    txSt_q    <= TX_DATA;
                    txSh_q    <= fifoData[7:0];
                    txLastB_q <= fifoData[8];
                    txInfo_q  <= txInfo_q + 1'b1;
                  end else begin
                    txSh_q <= addrOct;
                  end
                end
              end
            end
          end
          TX_ABORT: begin
            txBit_q  <= 1'b1;
            txOnes_q <= '0;
            txCnt_q  <= txCnt_q + 1'b1;
            if (txCnt_q == ABORT_ONES - 1'b1) begin
              txSt_q  <= TX_IDLE;
              txIdx_q <= '0;
            end
          end
          default: begin
            txSt_q <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // receive deframer
  logic [7:0]  rawSh_q;
  logic [3:0]  skip_q;
  logic        inFrame_q;
  logic [2:0]  rxOnes_q;
  logic [11:0] bitCnt_q;
  logic [15:0] dly_q;
  logic [4:0]  fill_q;
  logic [15:0] rxCrc_q;
  logic [7:0]  rxSh_q;
  logic [2:0]  rxIdx_q;
  logic [8:0]  rxByte_q;
  logic        err_q;
  logic        addrDone_q;
  logic [8:0]  ctrlIdx_q;
  logic        iFrame_q;
  logic        infoOk_q;
  logic [8:0]  infoCnt_q;
  logic        hasRpt_q;
  logic        rptH_q;
  logic        allCall_q;

  logic [7:0]  rawNext;
  logic        flagSeen;
  logic        abortSeen;
  logic        dBit;
  logic        dataEn;
  logic        accept;
  logic        outBit;
  logic [7:0]  byteNext;
  logic        byteDone;
  logic        frameGood;

  assign rawNext   = {rawSh_q[6:0], rxBit};
  assign flagSeen  = rxBitValid && (rawNext == FLAG_BYTE);
  assign abortSeen = rxBitValid && (rawNext[6:0] == 7'h7F);
  // data lags seven raw bits: last bit is in before the closing flag completes
  assign dBit      = rawSh_q[6];
  assign dataEn    = rxBitValid && inFrame_q && (skip_q == '0);
  assign accept    = dataEn && !((rxOnes_q == STUFF_RUN) && !dBit);
  assign outBit    = dly_q[15];
  assign byteNext  = {outBit, rxSh_q[7:1]};
  assign byteDone  = accept && (fill_q[4]) && (rxIdx_q == 3'h7);
  assign frameGood = (bitCnt_q >= MIN_FRAME_BITS) && (bitCnt_q[2:0] == 3'h0) &&
                     (dly_q == ~rxCrc_q) && !err_q && addrDone_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rawSh_q   <= '0;
      skip_q    <= '0;
      inFrame_q <= 1'b0;
    end else if (rxBitValid) begin
      rawSh_q <= rawNext;
      if (skip_q != '0) begin
        skip_q <= skip_q - 1'b1;
      end
      if (flagSeen) begin
        inFrame_q <= 1'b1;
        skip_q    <= RAW_SKIP;
      end else if (abortSeen) begin
        inFrame_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxOnes_q <= '0;
      bitCnt_q <= '0;
      dly_q    <= '0;
      fill_q   <= '0;
      rxCrc_q  <= CRC_INIT;
      rxSh_q   <= '0;
      rxIdx_q  <= '0;
      err_q    <= 1'b0;
    end else if (flagSeen || abortSeen) begin
      rxOnes_q <= '0;
      bitCnt_q <= '0;
      fill_q   <= '0;
      rxCrc_q  <= CRC_INIT;
      rxIdx_q  <= '0;
      err_q    <= 1'b0;
    end else if (dataEn) begin
      if (!accept) begin
        rxOnes_q <= '0;
      end else begin
        rxOnes_q <= dBit ? rxOnes_q + 1'b1 : 3'h0;
        if (dBit && rxOnes_q == STUFF_RUN) begin
          err_q <= 1'b1;
        end
        if (bitCnt_q != '1) begin
          bitCnt_q <= bitCnt_q + 1'b1;
        end
        // last 16 bits held back as the check sequence
        dly_q <= {dly_q[14:0], dBit};
        if (!fill_q[4]) begin
          fill_q <= fill_q + 1'b1;
        end else begin
          rxCrc_q <= crcStep(rxCrc_q, outBit);
          rxSh_q  <= byteNext;
          rxIdx_q <= rxIdx_q + 1'b1;
        end
      end
    end
  end

  // field parsing on recovered octets
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxByte_q   <= '0;
      addrDone_q <= 1'b0;
      ctrlIdx_q  <= '0;
      iFrame_q   <= 1'b0;
      infoOk_q   <= 1'b0;
      infoCnt_q  <= '0;
      hasRpt_q   <= 1'b0;
      rptH_q     <= 1'b0;
      allCall_q  <= 1'b0;
      rxData_q   <= '0;
      rxValid_q  <= 1'b0;
      rxPidClass_q <= PID_RSVD;
    end else begin
      rxValid_q <= byteDone;
      if (flagSeen || abortSeen) begin
        rxByte_q   <= '0;
        addrDone_q <= 1'b0;
        hasRpt_q   <= 1'b0;
        rptH_q     <= 1'b0;
        infoCnt_q  <= '0;
        iFrame_q   <= 1'b0;
        infoOk_q   <= 1'b0;
      end else if (byteDone) begin
        rxData_q <= byteNext;
        if (rxByte_q != '1) begin
          rxByte_q <= rxByte_q + 1'b1;
        end
        if (!addrDone_q) begin
          if (byteNext[0]) begin
            addrDone_q <= 1'b1;
            ctrlIdx_q  <= rxByte_q + 1'b1;
          end
          if (rxByte_q == DST_SSID_IDX) begin
            allCall_q <= (byteNext[4:1] == SSID_ALLCALL);
          end
          if (rxByte_q == SRC_SSID_IDX) begin
            hasRpt_q <= !byteNext[0];
          end
          if (rxByte_q == RPT_SSID_IDX) begin
            rptH_q <= byteNext[7];
          end
        end else if (rxByte_q == ctrlIdx_q) begin
          iFrame_q <= !byteNext[0];
          infoOk_q <= !byteNext[0] || ((byteNext & CTRL_PF_MASK) == CTRL_UI) ||
                      ((byteNext & CTRL_PF_MASK) == CTRL_FRMR);
        end else if (iFrame_q && rxByte_q == ctrlIdx_q + 1'b1) begin
          if (byteNext == PID_NONE_VAL) begin
            rxPidClass_q <= PID_NONE;
          end else if (byteNext == PID_ESC_VAL) begin
            rxPidClass_q <= PID_ESC;
          end else if (byteNext[5:4] == 2'h1 || byteNext[5:4] == 2'h2) begin
            rxPidClass_q <= PID_L3;
          end else begin
            rxPidClass_q <= PID_RSVD;
          end
        end else if (infoCnt_q != '1) begin
          infoCnt_q <= infoCnt_q + 1'b1;
        end
      end
    end
  end

  // frame verdict at closing flag or abort
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxFrameOk_q  <= 1'b0;
      rxFrameBad_q <= 1'b0;
      rxHasRpt_q   <= 1'b0;
      rxRepeated_q <= 1'b0;
      rxAllCall_q  <= 1'b0;
    end else begin
      rxFrameOk_q  <= 1'b0;
      rxFrameBad_q <= 1'b0;
      if (inFrame_q && (bitCnt_q != '0) && (flagSeen || abortSeen)) begin
        if (flagSeen && frameGood && (infoOk_q || infoCnt_q == '0) && infoCnt_q <= MAX_INFO) begin
          rxFrameOk_q  <= 1'b1;
          rxHasRpt_q   <= hasRpt_q;
          rxRepeated_q <= hasRpt_q && rptH_q;
          rxAllCall_q  <= allCall_q;
        end else begin
          rxFrameBad_q <= 1'b1;
        end
      end
    end
  end

  a_stuff_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (bitEn && stuffNow && !txAbort) |=> !txBit_q) else $error("stuffed zero missing");
  a_abort_ones: assert property (@(posedge clk_sys) disable iff (rst)
    (bitEn && txSt_q == TX_ABORT) |=> txBit_q) else $error("abort bit not one");
  a_fcs_msb_first: assert property (@(posedge clk_sys) disable iff (rst)
    (bitEn && txSt_q == TX_FCS && !stuffNow && !txAbort) |=> txBit_q == $past(txFcs_q[15]))
    else $error("fcs bit order wrong");
  a_idle_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (bitEn && txSt_q == TX_IDLE) |=> txBit_q == FLAG_BYTE[$past(txIdx_q)]) else $error("flag bit wrong");
  a_addr_ext_last: assert property (@(posedge clk_sys) disable iff (rst)
    (byteEnd && !txAbort && txSt_q == TX_ADDR && nIdx == lastAddr) |=> txSh_q[0])
    else $error("final address extension clear");
  a_addr_ext_more: assert property (@(posedge clk_sys) disable iff (rst)
    (byteEnd && !txAbort && txSt_q == TX_ADDR && nIdx < lastAddr) |=> !txSh_q[0])
    else $error("extension set too early");
  a_rx_short_bad: assert property (@(posedge clk_sys) disable iff (rst)
    (flagSeen && inFrame_q && bitCnt_q != '0 && bitCnt_q < MIN_FRAME_BITS) |=> rxFrameBad_q && !rxFrameOk_q)
    else $error("short frame accepted");
  a_rx_destuff: assert property (@(posedge clk_sys) disable iff (rst)
    (dataEn && rxOnes_q == STUFF_RUN && !dBit) |-> !accept ##1 rxOnes_q == 3'h0)
    else $error("stuffed zero kept");
  a_rx_crc_bad: assert property (@(posedge clk_sys) disable iff (rst)
    (flagSeen && inFrame_q && bitCnt_q != '0 && dly_q != ~rxCrc_q) |=> !rxFrameOk_q)
    else $error("bad check sequence accepted");
  a_strobe_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    txBitStrobe_q && (BIT_DIVIDE > 1) |=> !txBitStrobe_q) else $error("bit strobe too long");

  c_frame_sent: cover property (@(posedge clk_sys) disable iff (rst)
    bitEn && txSt_q == TX_FCS && txCnt_q == 5'(FCS_LAST_BIT) && !stuffNow);
  c_abort_sent: cover property (@(posedge clk_sys) disable iff (rst) txSt_q == TX_ABORT);
  c_rx_good: cover property (@(posedge clk_sys) disable iff (rst) rxFrameOk_q);
  c_rx_repeated: cover property (@(posedge clk_sys) disable iff (rst) rxFrameOk_q && rxRepeated_q);
endmodule : ax25_frame_codec

`default_nettype wire

// >>> tb/ax25_modem_model.sv
/*
  ax25_modem_model: loopback modem, echoes each line bit to the receiver.
  assumes one txBitStrobe_q pulse per line bit, all on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module ax25_modem_model (
  // clock and bench control
  input  wire logic clk_sys,
  input  wire logic clrRun,
  input  wire logic corrupt,
  // line from the codec
  input  wire logic txBit_q,
  input  wire logic txBitStrobe_q,
  // line back to the codec
  output logic      rxBit,
  output logic      rxBitValid,
  // line statistics
  output int        maxRun,
  output int        nFlags
);
  int         onesRun;
  logic [7:0] hist;
  always_ff @(posedge clk_sys) begin
    rxBitValid <= txBitStrobe_q;
    // idle line toggles so no stale level looks like data
    rxBit <= txBitStrobe_q ? txBit_q ^ corrupt : ~rxBit;
  end
  always_ff @(posedge clk_sys) begin
    if (clrRun) begin
      onesRun <= 0;
      maxRun <= 0;
      nFlags <= 0;
      hist <= 8'h00;
    end else if (txBitStrobe_q) begin
      onesRun <= txBit_q ? onesRun + 1 : 0;
      if (txBit_q && onesRun + 1 > maxRun) maxRun <= onesRun + 1;
      hist <= {txBit_q, hist[7:1]};
      if ({txBit_q, hist[7:1]} == 8'h7E) nFlags <= nFlags + 1;
    end
  end
endmodule : ax25_modem_model
`default_nettype wire

// >>> tb/test_ax25_frame_codec.sv
/*
  test_ax25_frame_codec: loopback bench for the frame codec.
  assumes ax25_modem_model echoes every line bit back to the receiver.
*/
`timescale 1ns/1ns
`default_nettype none
module test_ax25_frame_codec import ax25_pkg::*;;
  logic        clk_sys, rst, txValid, txLast, txReady, txAbort, rptEnable, rptDone;
  logic        txBit_q, txBitStrobe_q, txBusy_q, rxBit, rxBitValid, rxValid_q;
  logic        rxFrameOk_q, rxFrameBad_q, rxHasRpt_q, rxRepeated_q, rxAllCall_q;
  logic        clrRun, corrupt, gotOk, gotBad;
  logic [7:0]  txData, rxData_q;
  logic [3:0]  dstSsid, srcSsid, rptSsid;
  logic [47:0] dstCall, srcCall, rptCall;
  ax25_pid_t   rxPidClass_q;
  int          maxRun, nFlags, nMismatch, nChecks, cyc;
  logic [7:0]  rxQ[$], expQ[$];
  logic [7:0]  cont[8] = '{8'h10, 8'hF0, 8'hFF, 8'hFF, 8'h55, 8'hAA, 8'h12, 8'h34};

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ax25_frame_codec #(.BIT_DIVIDE(4), .FIFO_DEPTH(8)) dut_u (.clk_sys, .rst, .txValid, .txData, .txLast,
    .txReady, .txAbort, .dstCall, .dstSsid, .srcCall, .srcSsid, .rptEnable, .rptCall, .rptSsid, .rptDone,
    .txBit_q, .txBitStrobe_q, .txBusy_q, .rxBit, .rxBitValid, .rxData_q, .rxValid_q, .rxFrameOk_q,
    .rxFrameBad_q, .rxHasRpt_q, .rxRepeated_q, .rxAllCall_q, .rxPidClass_q);
  ax25_modem_model modem_u (.clk_sys, .clrRun, .corrupt, .txBit_q, .txBitStrobe_q, .rxBit, .rxBitValid,
    .maxRun, .nFlags);

  always @(posedge clk_sys) begin
    if (rxValid_q) rxQ.push_back(rxData_q);
    if (rxFrameOk_q) gotOk <= 1'b1;
    if (rxFrameBad_q) gotBad <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      nMismatch++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic expAddr(input logic [47:0] call, input logic [3:0] ssid, input logic b7, input logic ext);
    logic [7:0] c;
    for (int i = 5; i >= 0; i--) begin
      c = call[8*i +: 8];
      expQ.push_back({(c == 8'h00) ? 7'h20 : c[6:0], 1'b0});
    end
    expQ.push_back({b7, 2'b11, ssid, ext});
  endtask : expAddr

  // pushes n content bytes, optionally corrupts or aborts, waits for the verdict
  task automatic runFrame(input logic rp, input int n, input int hitAt, input logic ab);
    int t;
    rxQ.delete();
    {rptEnable, rptDone, gotOk, gotBad, clrRun} = {rp, rp, 3'b001};
    @(negedge clk_sys);
    clrRun = 1'b0;
    for (int i = 0; i < n; i++) begin
      {txValid, txData, txLast} = {1'b1, cont[i], i == n - 1};
      expQ.push_back(cont[i]);
      while (txReady !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
    end
    txValid = 1'b0;
    @(negedge clk_sys);
    if (n == 8) check("fifoFull", txReady, 0);
    if (hitAt > 0) begin
      repeat (hitAt) @(negedge clk_sys iff txBitStrobe_q);
      {corrupt, txAbort} = {~ab, ab};
      repeat (20) @(negedge clk_sys iff txBitStrobe_q);
      {corrupt, txAbort} = 2'b00;
    end
    for (t = 0; !(gotOk || gotBad) && t < 5000; t++) @(negedge clk_sys);
  endtask : runFrame

  task automatic cmpBytes();
    check("rxCount", rxQ.size(), expQ.size());
    foreach (expQ[i]) check("rxByte", rxQ[i], expQ[i]);
  endtask : cmpBytes

  task automatic idleFlags();
    repeat (40) @(negedge clk_sys iff txBitStrobe_q);
    check("idleFlags", nFlags >= 4, 1);
    check("idleBusy", txBusy_q, 0);
  endtask : idleFlags

  task automatic plainFrame();
    expQ.delete();
    expAddr(dstCall, dstSsid, 1'b1, 1'b0);
    expAddr(srcCall, srcSsid, 1'b1, 1'b1);
    runFrame(1'b0, 8, 0, 1'b0);
    check("plainOk", {gotOk, gotBad}, 2'b10);
    check("stuffRun", maxRun <= 6, 1);
    check("allCall", rxAllCall_q, 1);
    check("pidClass", rxPidClass_q, PID_NONE);
    cmpBytes();
  endtask : plainFrame

  task automatic rptFrame();
    rptCall = {"RPT", 24'h000000};
    rptSsid = 4'h9;
    expQ.delete();
    expAddr(dstCall, dstSsid, 1'b1, 1'b0);
    expAddr(srcCall, srcSsid, 1'b1, 1'b0);
    expAddr(rptCall, rptSsid, 1'b1, 1'b1);
    runFrame(1'b1, 3, 0, 1'b0);
    check("rptOk", {gotOk, gotBad}, 2'b10);
    check("rptFlags", {rxHasRpt_q, rxRepeated_q}, 2'b11);
    cmpBytes();
  endtask : rptFrame

  task automatic badFrame();
    runFrame(1'b0, 8, 60, 1'b0);
    check("corruptBad", {gotOk, gotBad}, 2'b01);
  endtask : badFrame

  task automatic abortFrame();
    runFrame(1'b0, 8, 60, 1'b1);
    check("abortRun", maxRun >= 15, 1);
    check("abortBad", gotBad, 1);
  endtask : abortFrame

  initial begin
    {txValid, txLast, txAbort, rptEnable, rptDone, corrupt, gotOk, gotBad} = 8'h00;
    {rst, clrRun, txData, cyc, nMismatch, nChecks} = {2'b11, 8'h00, 96'h0};
    {dstCall, srcCall, rptCall} = {"DST1", 16'h0000, "SRC2", 16'h0000, 48'h0};
    {dstSsid, srcSsid, rptSsid} = {4'hF, 4'h3, 4'h0};
    repeat (8) @(negedge clk_sys);
    {rst, clrRun} = 2'b00;
    idleFlags();
    plainFrame();
    rptFrame();
    badFrame();
    abortFrame();
    conclude();
  end
endmodule : test_ax25_frame_codec
`default_nettype wire
